/* File: pkg/mic_regs.svh */
// Constants of the interrupt controller: addresses, fields, resets, timing
`ifndef MIC_REGS_SVH
`define MIC_REGS_SVH

// ****************************************
// Register addresses (chosen, byte addresses on the core's data bus)
// ****************************************
`define MIC_ADDR_REQ_LOW 8'hE0
`define MIC_ADDR_REQ_HIGH 8'hE1
`define MIC_ADDR_MASK_LOW 8'hE4
`define MIC_ADDR_MASK_HIGH 8'hE5
`define MIC_ADDR_EDGE_A 8'hEC
`define MIC_ADDR_EDGE_B 8'hED
`define MIC_ADDR_KEY_MODE 8'hF5

// ****************************************
// Reset values
// ****************************************
`define MIC_REQ_RESET 8'h00
`define MIC_MASK_RESET 8'hFF

// ****************************************
// Field positions: source index = priority; low byte holds 0-5 and 13 at bit 7, high byte holds 6-12
// ****************************************
`define MIC_NSRC 14
`define MIC_REQ_LOW_RSVD 6
`define MIC_REQ_HIGH_RSVD 7
`define MIC_WDT_BIT 0

// ****************************************
// Vectors and timing
// ****************************************
`define MIC_VEC_NMI 16'h0004
`define MIC_VEC_BASE 16'h0006
`define MIC_VEC_STEP2 16'h0012
`define MIC_LAT_MIN_CLK 9
`define MIC_LAT_MAX_CLK 19

`endif

/* File: pkg/mic_pkg.sv */
// Types of the interrupt controller
package mic_pkg;
	// Arbiter state: idle or waiting for the core to take the vector
	typedef enum logic [0:0] {
		MIC_IDLE,
		MIC_WAIT_ACK
	} mic_state_t;
	// Edge selection codes of the external pins
	typedef enum logic [1:0] {
		MIC_EDGE_FALL = 2'h0,
		MIC_EDGE_RISE = 2'h1,
		MIC_EDGE_BAD = 2'h2,
		MIC_EDGE_BOTH = 2'h3
	} mic_edge_t;
endpackage

/* File: pkg/mic_arb_if.sv */
// Interface between the controller core and its priority encoder
`timescale 1ns/100ps
interface mic_arb_if;
	logic [13:0] pending; // Flag and not masked
	logic hit; // Some source is acceptable
	logic [3:0] index; // Winning source number
	modport ctrl (output pending, input hit, input index);
	modport enc (input pending, output hit, output index);
endinterface

/* File: hw/mic_prio_enc.sv */
// Fixed priority encoder: lowest index wins
`timescale 1ns/100ps
module mic_prio_enc (
	mic_arb_if.enc arb
);
	// ****************************************
	// Scan from the top, the lowest hit wins
	// ****************************************
	// Combinational scan from highest index down so lowest overrides
	always_comb begin
		arb.hit = 1'b0;
		arb.index = 4'h0;
		for (int i = 13; i >= 0; i--) begin
			if (arb.pending[i]) begin
				arb.hit = 1'b1;
				arb.index = 4'(i);
			end
		end
	end
endmodule

/* File: hw/mic_ctrl.sv */
// Interrupt controller of the small core: flags, masks, edges, vectors
`timescale 1ns/100ps
`include "mic_regs.svh"

// Contract
// - NMI ignores masks, always wins
// - Any request raises standby release (here only NMI and unmasked flags do)
// - Lowest priority number wins arbitration
// - Watchdog mode one: NMI at 0004H
// - Interval mode: watchdog maskable, priority 0
// - Pins a-d: priorities 1-4, vectors 0006H-000CH
// - Serial rx and three-wire share flag 5
// - Serial transmit: priority 6 at 0012H
// - Timers: priorities 8-10, 0016H-001AH
// - Interval 7, conversion 11, watch 12
// - Key return lowest, 13 at 0020H
// - Flags set by source/write, cleared otherwise
// - Request registers bit/byte writable, reset zero
// - Watchdog flag usable only in interval mode
// - Pin d output toggles still set flag
// - Mask zero allows, one blocks
// - Mask registers bit/byte writable, reset ones
// - Watchdog mask reads undefined in watchdog mode
// - Bit and byte writes both accepted
// - Vector only if flag, unmasked, enabled
// - Acknowledge clears flag; core stacks, clears enable
// - Edge code: fall, rise, prohibited, both
// - Latency between 9 and 19 clocks
module mic_ctrl (
	input wire logic i_ref_clk,
	input wire logic i_rstn,
	input wire logic i_clk_en,
	// Core data bus
	input wire logic i_wr,
	input wire logic i_bit_op,
	input wire logic [2:0] i_bit_sel,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	output logic [7:0] o_rdata,
	// Core interrupt handshake
	input wire logic i_global_irq_enable,
	input wire logic i_ack,
	output logic o_irq_req,
	output logic o_nmi_req,
	output logic [15:0] o_vector,
	output logic o_standby_release,
	// Sources
	input wire logic i_wdt_interval_mode,
	input wire logic i_watchdog_overflow_req,
	input wire logic [3:0] i_ext_pin,
	input wire logic [3:0] i_key_pin,
	input wire logic i_serial_rx_done_req,
	input wire logic i_three_wire_done_req,
	input wire logic i_serial_tx_done_req,
	input wire logic i_interval_tick_req,
	input wire logic i_wide_timer_match_req,
	input wire logic i_byte_timer_a_match_req,
	input wire logic i_byte_timer_b_match_req,
	input wire logic i_conversion_done_req,
	input wire logic i_watch_tick_req
);
	// ****************************************
	// Registers
	// ****************************************
	logic [13:0] req_r; // Request flags, index = priority
	logic [13:0] mask_r; // Mask flags
	logic [7:0] req_low_bits; // Low request byte merged with write data
	logic [7:0] mask_hi_bits; // Low mask byte merged with write data
	logic req_rsv_r; // Stored reserved request bit 6 of low byte
	logic req_rsv7_r; // Stored reserved request bit 7 of high byte
	logic mask_rsv_r; // Stored reserved mask bit 6 of low byte
	logic mask_rsv7_r; // Stored reserved mask bit 7 of high byte
	logic [7:0] edge_a_r; // Edge codes for pins a-c
	logic [1:0] edge_b_r; // Edge code for pin d
	logic key_mode_r; // Key return detection enable
	mic_pkg::mic_state_t state_r; // Handshake state
	logic [3:0] grant_r; // Index under service
	logic grant_nmi_r; // Grant is the non-maskable one
	logic nmi_pend_r; // Non-maskable request latched
	logic [3:0] pin_s1_r, pin_s2_r, pin_d_r; // Pin sync and history
	logic [3:0] key_s1_r, key_s2_r, key_d_r; // Key sync and history
	// Outputs from flip-flops
	logic [7:0] rdata_r;
	logic irq_r, nmi_r, stb_r;
	logic [15:0] vec_r;

	// ****************************************
	// Priority encoder
	// ****************************************
	mic_arb_if arb ();
	mic_prio_enc u_enc (
		.arb(arb)
	);
	// Pending only when flagged and unmasked; enable gates later, in want_irq
	assign arb.pending = req_r & ~mask_r;

	// ****************************************
	// Source events
	// ****************************************
	// Pin edge detect: data from two sync stages only
	logic [3:0] pin_rise, pin_fall, pin_evt;
	logic [7:0] pin_code;
	assign pin_code = {edge_b_r, edge_a_r[7:2]};
	assign pin_rise = pin_s2_r & ~pin_d_r;
	assign pin_fall = ~pin_s2_r & pin_d_r;
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_pin
			// Prohibited code treated as no detection
			assign pin_evt[g] =
				(pin_code[2*g+:2] == mic_pkg::MIC_EDGE_FALL) ? pin_fall[g] :
				(pin_code[2*g+:2] == mic_pkg::MIC_EDGE_RISE) ? pin_rise[g] :
				(pin_code[2*g+:2] == mic_pkg::MIC_EDGE_BOTH) ?
				(pin_rise[g] | pin_fall[g]) : 1'b0;
		end
	endgenerate
	// Pin d level follows the port even when it drives out
	logic key_evt;
	assign key_evt = key_mode_r & |(~key_s2_r & key_d_r);

	// Watchdog routed to exactly one path
	logic wdt_maskable, wdt_nmi;
	assign wdt_maskable = i_wdt_interval_mode & i_watchdog_overflow_req;
	assign wdt_nmi = ~i_wdt_interval_mode & i_watchdog_overflow_req;

	// Event vector by priority
	logic [13:0] src_evt;
	assign src_evt = {
		key_evt,
		i_watch_tick_req, i_conversion_done_req,
		i_byte_timer_b_match_req, i_byte_timer_a_match_req,
		i_wide_timer_match_req,
		i_interval_tick_req,
		i_serial_tx_done_req,
		i_serial_rx_done_req | i_three_wire_done_req,
		pin_evt,
		wdt_maskable
	};

	// ****************************************
	// Register writes
	// ****************************************
	// Byte or single-bit write data merged with current value
	// Write controls come in as arguments so every assign that calls
	// this re-evaluates when the bus changes, not only when cur changes
	function automatic logic [7:0] merge(input logic [7:0] cur,
		input logic bop, input logic [2:0] sel, input logic [7:0] wd);
		logic [7:0] res;
		res = cur;
		if (bop) begin
			res[sel] = wd[0];
		end else begin
			res = wd;
		end
		return res;
	endfunction

	logic wr_req_lo, wr_req_hi, wr_msk_lo, wr_msk_hi;
	assign wr_req_lo = i_wr & (i_addr == `MIC_ADDR_REQ_LOW);
	assign wr_req_hi = i_wr & (i_addr == `MIC_ADDR_REQ_HIGH);
	assign wr_msk_lo = i_wr & (i_addr == `MIC_ADDR_MASK_LOW);
	assign wr_msk_hi = i_wr & (i_addr == `MIC_ADDR_MASK_HIGH);

	// Byte views: low byte holds 0..5, reserved 6, 13 at bit 7
	logic [7:0] req_lo_v, req_hi_v, msk_lo_v, msk_hi_v;
	assign req_lo_v = {req_r[13], req_rsv_r, req_r[5:0]};
	assign req_hi_v = {req_rsv7_r, req_r[12:6]};
	assign msk_lo_v = {mask_r[13], mask_rsv_r, mask_r[5:0]};
	assign msk_hi_v = {mask_rsv7_r, mask_r[12:6]};
	assign req_low_bits = merge(req_lo_v, i_bit_op, i_bit_sel, i_wdata);
	assign mask_hi_bits = merge(msk_lo_v, i_bit_op, i_bit_sel, i_wdata);
	logic [7:0] req_hi_w, msk_hi_w;
	assign req_hi_w = merge(req_hi_v, i_bit_op, i_bit_sel, i_wdata);
	assign msk_hi_w = merge(msk_hi_v, i_bit_op, i_bit_sel, i_wdata);

	// Software image of request and mask flags after any write
	logic [13:0] req_sw, msk_sw;
	assign req_sw = wr_req_lo ? {req_low_bits[7], req_r[12:6],
		req_low_bits[5:0]} :
		wr_req_hi ? {req_r[13], req_hi_w[6:0], req_r[5:0]} : req_r;
	assign msk_sw = wr_msk_lo ? {mask_hi_bits[7], mask_r[12:6],
		mask_hi_bits[5:0]} :
		wr_msk_hi ? {mask_r[13], msk_hi_w[6:0], mask_r[5:0]} : mask_r;

	// Acknowledge clears the granted flag
	logic [13:0] ack_clr;
	assign ack_clr = (i_ack && state_r == mic_pkg::MIC_WAIT_ACK &&
		!grant_nmi_r) ? (14'h0001 << grant_r) : 14'h0000;

	// Watchdog flag held at zero outside interval mode
	logic [13:0] req_nxt;
	assign req_nxt = (((req_sw & ~ack_clr) | src_evt) &
		~{13'h0000, ~i_wdt_interval_mode});

	// Flags, masks and mode registers; set wins over clear
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			req_r <= 14'h0000;
			mask_r <= 14'h3FFF;
			req_rsv_r <= 1'b0;
			req_rsv7_r <= 1'b0;
			mask_rsv_r <= 1'b1;
			mask_rsv7_r <= 1'b1;
			edge_a_r <= 8'h00;
			edge_b_r <= 2'h0;
			key_mode_r <= 1'b0;
		end else if (i_clk_en) begin
			req_r <= req_nxt;
			mask_r <= msk_sw;
			// Reserved bits stored as written; software keeps them fixed
			if (wr_req_lo) req_rsv_r <= req_low_bits[6];
			if (wr_req_hi) req_rsv7_r <= req_hi_w[7];
			if (wr_msk_lo) mask_rsv_r <= mask_hi_bits[6];
			if (wr_msk_hi) mask_rsv7_r <= msk_hi_w[7];
			if (i_wr && i_addr == `MIC_ADDR_EDGE_A) edge_a_r <= i_wdata;
			if (i_wr && i_addr == `MIC_ADDR_EDGE_B) edge_b_r <= i_wdata[1:0];
			if (i_wr && i_addr == `MIC_ADDR_KEY_MODE) key_mode_r <= i_wdata[0];
		end
	end

	// Two-stage synchronisers and edge history for pins
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			pin_s1_r <= 4'hF;
			pin_s2_r <= 4'hF;
			pin_d_r <= 4'hF;
			key_s1_r <= 4'hF;
			key_s2_r <= 4'hF;
			key_d_r <= 4'hF;
		end else if (i_clk_en) begin
			pin_s1_r <= i_ext_pin;
			pin_s2_r <= pin_s1_r;
			pin_d_r <= pin_s2_r;
			key_s1_r <= i_key_pin;
			key_s2_r <= key_s1_r;
			key_d_r <= key_s2_r;
		end
	end

	// ****************************************
	// Read data
	// ****************************************
	// Watchdog mask reads as zero (undefined) outside interval mode
	logic [7:0] rd_sel;
	assign rd_sel =
		(i_addr == `MIC_ADDR_REQ_LOW) ? req_lo_v :
		(i_addr == `MIC_ADDR_REQ_HIGH) ? req_hi_v :
		(i_addr == `MIC_ADDR_MASK_LOW) ?
		(msk_lo_v & {7'h7F, i_wdt_interval_mode}) :
		(i_addr == `MIC_ADDR_MASK_HIGH) ? msk_hi_v :
		(i_addr == `MIC_ADDR_EDGE_A) ? {edge_a_r[7:2], 2'h0} :
		(i_addr == `MIC_ADDR_EDGE_B) ? {6'h00, edge_b_r} :
		(i_addr == `MIC_ADDR_KEY_MODE) ? {7'h00, key_mode_r} : 8'h00;

	// ****************************************
	// Vector handshake
	// ****************************************
	// Vector table: index 0 shares NMI slot only in interval mode
	logic [15:0] vec_of;
	assign vec_of = (arb.index < 4'h6) ?
		(`MIC_VEC_BASE + {11'h000, arb.index - 4'h1, 1'b0}) :
		(`MIC_VEC_STEP2 + {11'h000, arb.index - 4'h6, 1'b0});
	logic [15:0] vec_mask;
	assign vec_mask = (arb.index == 4'h0) ? `MIC_VEC_NMI : vec_of;

	logic want_nmi, want_irq;
	assign want_nmi = nmi_pend_r | wdt_nmi;
	assign want_irq = arb.hit & i_global_irq_enable;

	// Present one request, hold it until the core acknowledges or a maskable one is withdrawn
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			state_r <= mic_pkg::MIC_IDLE;
			grant_r <= 4'h0;
			grant_nmi_r <= 1'b0;
			nmi_pend_r <= 1'b0;
			irq_r <= 1'b0;
			nmi_r <= 1'b0;
			vec_r <= 16'h0000;
			stb_r <= 1'b0;
			rdata_r <= 8'h00;
		end else if (i_clk_en) begin
			rdata_r <= rd_sel;
			// Standby release on a new or latched NMI or any unmasked pending request
			stb_r <= wdt_nmi | (|arb.pending) | nmi_pend_r;
			if (wdt_nmi) nmi_pend_r <= 1'b1;
			case (state_r)
				mic_pkg::MIC_IDLE: begin
					if (want_nmi) begin
						// Non-maskable beats every maskable one
						state_r <= mic_pkg::MIC_WAIT_ACK;
						grant_nmi_r <= 1'b1;
						nmi_r <= 1'b1;
						vec_r <= `MIC_VEC_NMI;
					end else if (want_irq) begin
						state_r <= mic_pkg::MIC_WAIT_ACK;
						grant_nmi_r <= 1'b0;
						grant_r <= arb.index;
						irq_r <= 1'b1;
						vec_r <= vec_mask;
					end
				end
				mic_pkg::MIC_WAIT_ACK: begin
					if (i_ack) begin
						// Flag clear rides ack_clr; core stacks state
						state_r <= mic_pkg::MIC_IDLE;
						irq_r <= 1'b0;
						nmi_r <= 1'b0;
						if (grant_nmi_r && !wdt_nmi) nmi_pend_r <= 1'b0;
					end else if (!grant_nmi_r &&
						(!i_global_irq_enable || !arb.pending[grant_r])) begin
						// Withdrawn request goes back to idle
						state_r <= mic_pkg::MIC_IDLE;
						irq_r <= 1'b0;
					end
				end
				default: begin
					state_r <= mic_pkg::MIC_IDLE;
				end
			endcase
		end
	end

	assign o_rdata = rdata_r;
	assign o_irq_req = irq_r;
	assign o_nmi_req = nmi_r;
	assign o_vector = vec_r;
	assign o_standby_release = stb_r;
	// Core-side latency of 9..19 clocks is the core's sequence
endmodule

/* File: verif/mic_ctrl_chk.sv */
// Port assertions of the interrupt controller, bound to its top
`timescale 1ns/100ps
`include "mic_regs.svh"
module mic_ctrl_chk (
	input wire logic i_ref_clk,
	input wire logic i_rstn,
	input wire logic i_ack,
	input wire logic i_global_irq_enable,
	input wire logic i_wdt_interval_mode,
	input wire logic i_watchdog_overflow_req,
	input wire logic o_irq_req,
	input wire logic o_nmi_req,
	input wire logic [15:0] o_vector,
	input wire logic o_standby_release
);
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_rstn);
	// Core takes a maskable grant
	sequence taken_s;
		o_irq_req && i_ack;
	endsequence
	// Overflow outside interval mode while no maskable grant is shown
	sequence nmi_cause_s;
		i_watchdog_overflow_req && !i_wdt_interval_mode && !o_irq_req;
	endsequence
	nmi_vector_a: assert property (
		o_nmi_req |-> o_vector == `MIC_VEC_NMI) else $error("bad nmi vector");
	vector_range_a: assert property (
		o_irq_req |-> !o_vector[0] && o_vector >= 16'h0004
		&& o_vector <= 16'h0020 && o_vector != 16'h0010)
		else $error("bad irq vector");
	irq_enable_a: assert property (
		$rose(o_irq_req) |-> $past(i_global_irq_enable))
		else $error("irq without enable");
	irq_withdraw_a: assert property (
		o_irq_req && !i_global_irq_enable |=> !o_irq_req)
		else $error("irq kept without enable");
	standby_wake_a: assert property (
		$rose(o_irq_req) || $rose(o_nmi_req) |-> o_standby_release)
		else $error("no standby release");
	ack_clear_a: assert property (
		taken_s |=> !o_irq_req) else $error("irq kept after ack");
	nmi_timing_a: assert property (
		nmi_cause_s |-> ##[1:3] o_nmi_req) else $error("nmi not raised");
	nmi_mode_a: assert property (
		$rose(o_nmi_req) |-> !$past(i_wdt_interval_mode))
		else $error("nmi in interval mode");
endmodule
bind mic_ctrl mic_ctrl_chk u_chk (
	.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_ack(i_ack),
	.i_global_irq_enable(i_global_irq_enable),
	.i_wdt_interval_mode(i_wdt_interval_mode),
	.i_watchdog_overflow_req(i_watchdog_overflow_req),
	.o_irq_req(o_irq_req), .o_nmi_req(o_nmi_req), .o_vector(o_vector),
	.o_standby_release(o_standby_release)
);

/* File: verif/mic_core_model.sv */
// Core model: takes vectors after a delay, serves, then returns
`timescale 1ns/100ps
module mic_core_model (
	input wire logic i_ref_clk,
	input wire logic i_rstn,
	input wire logic i_ie_on,
	input wire logic [3:0] i_delay,
	input wire logic i_irq_req,
	input wire logic i_nmi_req,
	output logic o_ack,
	output logic o_ie
);
	int cnt; // Cycles waited or served
	logic busy_r; // Service routine running
	// Enable is cleared while a routine runs
	assign o_ie = i_ie_on && !busy_r;
	// A slow core leaves the request standing
	always @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			cnt <= 0;
			busy_r <= 1'b0;
			o_ack <= 1'b0;
		end else begin
			o_ack <= 1'b0;
			if (busy_r || ((i_irq_req || i_nmi_req) && !o_ack)) begin
				cnt <= cnt + 1;
				if (cnt >= i_delay) begin
					cnt <= 0;
					busy_r <= !busy_r;
					o_ack <= !busy_r;
				end
			end else begin
				cnt <= 0;
			end
		end
	end
endmodule

/* File: verif/tb.sv */
// Self-checking bench of the interrupt controller
`timescale 1ns/100ps
`include "mic_regs.svh"
module tb;
	logic clk, rstn, wr, bop, ie_on, mode, tw, ack, ie, irq, nmi;
	logic [2:0] sel;
	logic [3:0] dly;
	logic [7:0] addr, wd, rdata, d;
	logic [13:0] src; // Source pulses; pins and keys active low
	logic [15:0] vec;
	logic [31:0] r;
	logic [31:0] seed = 32'h60E1CBF6;
	int err_total, tests_run, nmi_seen, w;
	int flg[14], msk[14]; // Reference flags and masks
	logic [7:0] ad[4] = '{`MIC_ADDR_REQ_LOW, `MIC_ADDR_REQ_HIGH,
		`MIC_ADDR_MASK_LOW, `MIC_ADDR_MASK_HIGH};
	logic [7:0] am[4] = '{8'hBF, 8'h7F, 8'hFF, 8'hFF};
	logic [7:0] om[4] = '{8'h00, 8'h00, 8'h40, 8'h80};
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	mic_ctrl uut (.i_ref_clk(clk), .i_rstn(rstn), .i_clk_en(1'b1),
		.i_wr(wr), .i_bit_op(bop), .i_bit_sel(sel), .i_addr(addr),
		.i_wdata(wd), .o_rdata(rdata), .i_global_irq_enable(ie),
		.i_ack(ack), .o_irq_req(irq), .o_nmi_req(nmi), .o_vector(vec),
		.o_standby_release(), .i_wdt_interval_mode(mode),
		.i_watchdog_overflow_req(src[0]), .i_ext_pin(~src[4:1]),
		.i_key_pin({3'h7, ~src[13]}), .i_serial_rx_done_req(src[5]),
		.i_three_wire_done_req(tw), .i_serial_tx_done_req(src[6]),
		.i_interval_tick_req(src[7]), .i_wide_timer_match_req(src[8]),
		.i_byte_timer_a_match_req(src[9]),
		.i_byte_timer_b_match_req(src[10]),
		.i_conversion_done_req(src[11]), .i_watch_tick_req(src[12]));
	mic_core_model core (.i_ref_clk(clk), .i_rstn(rstn), .i_ie_on(ie_on),
		.i_delay(dly), .i_irq_req(irq), .i_nmi_req(nmi), .o_ack(ack),
		.o_ie(ie));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [15:0] vec_of(input int i);
		if (i == 0) return `MIC_VEC_NMI;
		if (i < 6) return `MIC_VEC_BASE + 16'(2 * (i - 1));
		return `MIC_VEC_STEP2 + 16'(2 * (i - 6));
	endfunction
	function automatic int pend();
		pend = 0;
		for (int i = 0; i < 14; i++) if (flg[i] && !msk[i]) pend = 1;
	endfunction
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] %0t seen %h want %h", $time, seen, exp);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, dd, input logic b,
		input logic [2:0] s);
		@(posedge clk);
		#1 wr = 1'b1;
		addr = a;
		wd = dd;
		bop = b;
		sel = s;
		@(posedge clk);
		#1 wr = 1'b0;
	endtask
	task automatic rd_chk(input logic [7:0] a, exp);
		@(posedge clk);
		#1 addr = a;
		@(posedge clk);
		#1 chk({8'h00, rdata}, {8'h00, exp});
	endtask
	// Pins and keys stay low long enough to pass the synchroniser
	task automatic fire(input int i);
		if (i != 0 || mode) flg[i] = 1;
		@(posedge clk);
		#1 src[i] = 1'b1;
		repeat ((i inside {[1:4], 13}) ? 3 : 1) @(posedge clk);
		#1 src[i] = 1'b0;
	endtask
	task automatic settle();
		for (int k = 0; k < 200 && pend(); k++) @(posedge clk);
		#1 chk(16'(pend()), 16'h0000);
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// Reference arbiter: taken NMI vector against 0004H, every taken maskable vector against the lowest pending
	always @(posedge clk) begin
		if (ack && nmi) begin
			nmi_seen++;
			chk(vec, `MIC_VEC_NMI);
		end else if (ack && irq) begin
			w = -1;
			for (int i = 13; i >= 0; i--) if (flg[i] && !msk[i]) w = i;
			chk(vec, (w < 0) ? 16'hFFFF : vec_of(w));
			if (w >= 0) flg[w] = 0;
		end
	end
	initial begin
		#200000;
		err_total++;
		print_verdict();
	end
	initial begin
		{wr, bop, ie_on, tw} = 4'h0;
		mode = 1'b1;
		{sel, addr, wd, src, dly} = 37'h0;
		rstn = 1'b0;
		for (int i = 0; i < 14; i++) msk[i] = 1;
		repeat (3) @(posedge clk);
		#1 rstn = 1'b1;
		for (int j = 0; j < 4; j++) rd_chk(ad[j], j < 2 ? 8'h00 : 8'hFF);
		rd_chk(8'h10, 8'h00);
		wr_reg(`MIC_ADDR_KEY_MODE, 8'h01, 1'b0, 3'h0);
		repeat (3) for (int j = 0; j < 4; j++) begin
			r = rnd();
			d = (r[7:0] & am[j]) | om[j];
			wr_reg(ad[j], d, 1'b0, 3'h0);
			rd_chk(ad[j], d);
		end
		wr_reg(`MIC_ADDR_REQ_LOW, 8'h00, 1'b0, 3'h0);
		wr_reg(`MIC_ADDR_REQ_LOW, 8'h01, 1'b1, 3'h3);
		rd_chk(`MIC_ADDR_REQ_LOW, 8'h08);
		for (int j = 0; j < 4; j++) wr_reg(ad[j], om[j], 1'b0, 3'h0);
		for (int i = 0; i < 14; i++) msk[i] = 0;
		ie_on = 1'b1;
		for (int i = 0; i < 14; i++) begin
			r = rnd();
			dly = r[3:0];
			fire(i);
			settle();
		end
		tw = 1'b1;
		flg[5] = 1;
		@(posedge clk);
		#1 tw = 1'b0;
		settle();
		ie_on = 1'b0;
		r = rnd() | 32'h9;
		for (int i = 0; i < 14; i++) if (r[i]) fire(i);
		repeat (4) @(posedge clk);
		#1 ie_on = 1'b1;
		dly = 4'h3;
		for (int k = 0; k < 20 && !irq; k++) @(posedge clk);
		#1 ie_on = 1'b0;
		@(posedge clk);
		#1 ie_on = 1'b1;
		settle();
		wr_reg(`MIC_ADDR_MASK_LOW, 8'h01, 1'b1, 3'h1);
		msk[1] = 1;
		fire(1);
		repeat (`MIC_LAT_MAX_CLK) @(posedge clk);
		rd_chk(`MIC_ADDR_REQ_LOW, 8'h02);
		wr_reg(`MIC_ADDR_REQ_LOW, 8'h00, 1'b1, 3'h1);
		flg[1] = 0;
		rd_chk(`MIC_ADDR_REQ_LOW, 8'h00);
		ie_on = 1'b0;
		mode = 1'b0;
		wr_reg(`MIC_ADDR_MASK_LOW, 8'h01, 1'b1, 3'h0);
		msk[0] = 1;
		fire(0);
		for (int k = 0; k < 40 && nmi_seen == 0; k++) @(posedge clk);
		#1 chk(16'(nmi_seen), 16'h0001);
		wr_reg(`MIC_ADDR_REQ_LOW, 8'h01, 1'b1, 3'h0);
		rd_chk(`MIC_ADDR_REQ_LOW, 8'h00);
		rd_chk(`MIC_ADDR_MASK_LOW, 8'h42);
		for (int c = 0; c < 4; c++) begin
			wr_reg(`MIC_ADDR_EDGE_B, 8'(c), 1'b0, 3'h0);
			src[4] = 1'b1;
			repeat (3) @(posedge clk);
			rd_chk(`MIC_ADDR_REQ_LOW, c % 3 == 0 ? 8'h10 : 8'h00);
			wr_reg(`MIC_ADDR_REQ_LOW, 8'h00, 1'b1, 3'h4);
			src[4] = 1'b0;
			repeat (3) @(posedge clk);
			rd_chk(`MIC_ADDR_REQ_LOW, c % 2 == 1 ? 8'h10 : 8'h00);
			wr_reg(`MIC_ADDR_REQ_LOW, 8'h00, 1'b1, 3'h4);
		end
		print_verdict();
	end
endmodule
